// ---- pkg/irsm_pkg.sv ----
package irsm_pkg;
    localparam logic [15:0] RAM_BASE = 16'hf600;
    localparam logic [15:0] RAM_LAST = 16'hfdff;
    localparam logic [15:0] RAM_WORD_LAST = 16'hfdfe;
    localparam logic [15:0] SFR_BASE = 16'hfe00;
    localparam logic [15:0] SFR_LAST = 16'hffff;
    localparam logic [15:0] EXTENDED_SPECIAL_REGISTERS_BASE = 16'hf000;
    localparam logic [15:0] EXTENDED_SPECIAL_REGISTERS_LAST = 16'hf1ff;
    localparam logic [15:0] BIT_RAM_BASE = 16'hfd00;
    localparam logic [15:0] SFR_BIT_BASE = 16'hff00;
    localparam logic [15:0] EXTENDED_SPECIAL_REGISTERS_BIT_BASE = 16'hf100;
    localparam logic [15:0] EVT_PTR_BASE = 16'hfce0;
    localparam logic [15:0] EVT_PTR_LAST = 16'hfcfe;
    localparam logic [15:0] STACK_TOP = 16'hfbfe;
    localparam logic [15:0] STACK_TOP_MAX = 16'hfdfe;
    localparam logic [1:0] RAM_PAGE = 2'h3;
    localparam logic [2:0] STACK_SIZE_FIELD_RESET = 3'h0;
    localparam logic [2:0] STACK_SIZE_FIELD_MAX = 3'h7;
    localparam logic [15:0] SP_RESET = 16'hfc00;
    localparam logic [15:0] CP_RESET = 16'hfc00;
    localparam logic [4:0] GPR_LAST_OFS = 5'h1e;
    // wishbone register offsets (byte addresses)
    localparam logic [7:0] REG_SYSCFG = 8'h00;
    localparam logic [7:0] REG_SP = 8'h04;
    localparam logic [7:0] REG_LOWER = 8'h08;
    localparam logic [7:0] REG_UPPER = 8'h0c;
    localparam logic [7:0] REG_CP = 8'h10;
    localparam logic [7:0] REG_SAVED_CP = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    // access kinds presented on the cpu port
    typedef enum logic [2:0] {
        IRSM_LONG,
        IRSM_GPR,
        IRSM_PUSH,
        IRSM_POP,
        IRSM_EVT,
        IRSM_FETCH,
        IRSM_BIT
    } irsm_kind_type;
endpackage : irsm_pkg

// ---- src/irsm_core.sv ----
module irsm_core
    import irsm_pkg::*;
#(
    parameter int WORDS = 1024
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // cpu / event controller access port
    input wire logic req_i,
    input wire irsm_kind_type kind_i,
    input wire logic we_i,
    input wire logic byte_i,
    input wire logic [1:0] dpp_page_i,
    input wire logic [15:0] addr_i,
    input wire logic [4:0] reg_i,
    input wire logic [2:0] chan_i,
    input wire logic chan_dst_i,
    input wire logic [3:0] bit_i,
    input wire logic [15:0] wdata_i,
    input wire logic ctx_switch_i,
    input wire logic [15:0] ctx_new_i,
    output logic [15:0] rdata_o,
    output logic ack_o,
    output logic err_o,
    output logic sfr_sel_o,
    output logic extended_special_registers_sel_o
);
    logic [15:0] mem [WORDS];
    logic [2:0] stack_size_field_q;
    logic [15:0] sp_q;
    logic [15:0] lower_q;
    logic [15:0] upper_q;
    logic [15:0] cp_q;
    logic [15:0] saved_cp_q;
    logic [7:0] err_cnt_q;
    logic [15:0] ea_d;
    logic bad_d;
    logic in_ram_d;
    logic [15:0] sp_next_d;

    function automatic logic [9:0] word_idx(input logic [15:0] a);
        word_idx = 10'((a - RAM_BASE) >> 1);
    endfunction : word_idx

    function automatic logic [15:0] stack_bottom(input logic [2:0] sz);
        unique case (sz)
            3'h0: stack_bottom = 16'hfa00;
            3'h1: stack_bottom = 16'hfb00;
            3'h2: stack_bottom = 16'hfb80;
            3'h3: stack_bottom = 16'hfbc0;
            3'h4: stack_bottom = 16'hf800;
            3'h7: stack_bottom = RAM_BASE;
            default: stack_bottom = 16'hfa00;
        endcase
    endfunction : stack_bottom

    function automatic logic bit_ok(input logic [15:0] a);
        bit_ok = (a >= BIT_RAM_BASE && a <= RAM_LAST) || (a >= SFR_BIT_BASE)
            || (a >= EXTENDED_SPECIAL_REGISTERS_BIT_BASE && a <= EXTENDED_SPECIAL_REGISTERS_LAST);
    endfunction : bit_ok

    // effective address per access kind
    always_comb
    begin
        ea_d = addr_i;
        bad_d = 1'b0;
        sp_next_d = sp_q;
        unique case (kind_i)
            IRSM_LONG:
            begin
                ea_d = addr_i;
                bad_d = (dpp_page_i != RAM_PAGE) || (!byte_i && addr_i[0]);
            end
            IRSM_GPR:
            begin
                // page pointers play no part here
                ea_d = cp_q + {11'h0, reg_i[3:0], 1'b0};
                if (byte_i)
                    ea_d = cp_q + {12'h0, reg_i[3:1], reg_i[0]};
                bad_d = byte_i && reg_i[4];
            end
            IRSM_PUSH:
            begin
                sp_next_d = sp_q - 16'h2;
                ea_d = sp_next_d;
                bad_d = byte_i || sp_next_d < lower_q;
            end
            IRSM_POP:
            begin
                ea_d = sp_q;
                sp_next_d = sp_q + 16'h2;
                bad_d = byte_i || sp_q >= upper_q;
            end
            IRSM_EVT:
            begin
                ea_d = EVT_PTR_BASE + {11'h0, chan_i, chan_dst_i, 1'b0};
                bad_d = byte_i;
            end
            IRSM_FETCH:
            begin
                ea_d = addr_i;
                bad_d = addr_i[0];
            end
            IRSM_BIT:
            begin
                ea_d = {addr_i[15:1], 1'b0};
                bad_d = !bit_ok(addr_i);
            end
            default:
            begin
                ea_d = addr_i;
                bad_d = 1'b1;
            end
        endcase
        in_ram_d = ea_d >= RAM_BASE && ea_d <= RAM_LAST;
    end

    // active-bank bit access: reg_i names the word register
    logic gpr_bit_d;
    assign gpr_bit_d = kind_i == IRSM_BIT && byte_i;

    logic [15:0] bit_ea_d;
    assign bit_ea_d = gpr_bit_d ? cp_q + {11'h0, reg_i[3:0], 1'b0} : ea_d;

    logic [9:0] idx_d;
    assign idx_d = word_idx(bit_ea_d);

    logic hit_d;
    assign hit_d = req_i && (gpr_bit_d || (in_ram_d && !bad_d));

    // ram write: bytes land on lanes per address lsb
    always_ff @(posedge clk_i)
    begin
        if (ce_i && hit_d && we_i)
        begin
            if (kind_i == IRSM_BIT)
                mem[idx_d][bit_i] <= wdata_i[0];
            else if (byte_i && bit_ea_d[0])
                mem[idx_d][15:8] <= wdata_i[7:0];
            else if (byte_i)
                mem[idx_d][7:0] <= wdata_i[7:0];
            else
                mem[idx_d] <= wdata_i;
        end
    end

    // cpu port answer, one cycle after request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 16'h0;
            ack_o <= 1'b0;
            err_o <= 1'b0;
            sfr_sel_o <= 1'b0;
            extended_special_registers_sel_o <= 1'b0;
        end
        else if (ce_i)
        begin
            ack_o <= req_i;
            err_o <= req_i && !gpr_bit_d && (bad_d || !in_ram_d)
                && !(ea_d >= SFR_BASE || (ea_d >= EXTENDED_SPECIAL_REGISTERS_BASE && ea_d <= EXTENDED_SPECIAL_REGISTERS_LAST));
            sfr_sel_o <= req_i && !bad_d && ea_d >= SFR_BASE;
            extended_special_registers_sel_o <= req_i && !bad_d && ea_d >= EXTENDED_SPECIAL_REGISTERS_BASE && ea_d <= EXTENDED_SPECIAL_REGISTERS_LAST;
            if (hit_d)
            begin
                if (kind_i == IRSM_BIT)
                    rdata_o <= {15'h0, mem[idx_d][bit_i]};
                else if (byte_i && bit_ea_d[0])
                    rdata_o <= {8'h0, mem[idx_d][15:8]};
                else if (byte_i)
                    rdata_o <= {8'h0, mem[idx_d][7:0]};
                else
                    rdata_o <= mem[idx_d];
            end
            else
                rdata_o <= 16'h0;
        end
    end

    logic wb_req_d;
    assign wb_req_d = wb_cyc_i && wb_stb_i && !wb_ack_o;

    logic wb_wr_d;
    assign wb_wr_d = wb_req_d && wb_we_i && wb_sel_i[0];

    // stack configuration and limits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stack_size_field_q <= STACK_SIZE_FIELD_RESET;
            lower_q <= stack_bottom(STACK_SIZE_FIELD_RESET);
            upper_q <= STACK_TOP + 16'h2;
        end
        else if (ce_i && wb_wr_d)
        begin
            unique case (wb_adr_i)
                REG_SYSCFG:
                begin
                    // reserved codes are ignored, keeping the old size
                    if (wb_dat_i[2:0] != 3'h5 && wb_dat_i[2:0] != 3'h6)
                    begin
                        stack_size_field_q <= wb_dat_i[2:0];
                        lower_q <= stack_bottom(wb_dat_i[2:0]);
                        upper_q <= (wb_dat_i[2:0] == STACK_SIZE_FIELD_MAX ? STACK_TOP_MAX : STACK_TOP) + 16'h2;
                    end
                end
                REG_LOWER: lower_q <= {wb_dat_i[15:1], 1'b0};
                REG_UPPER: upper_q <= {wb_dat_i[15:1], 1'b0};
                default: ;
            endcase
        end
    end

    // stack pointer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sp_q <= SP_RESET;
        else if (ce_i)
        begin
            if (req_i && !bad_d && (kind_i == IRSM_PUSH || kind_i == IRSM_POP))
                sp_q <= sp_next_d;
            else if (wb_wr_d && wb_adr_i == REG_SP)
                sp_q <= {wb_dat_i[15:1], 1'b0};
        end
    end

    // context pointer and its saved copy
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cp_q <= CP_RESET;
            saved_cp_q <= CP_RESET;
        end
        else if (ce_i)
        begin
            if (ctx_switch_i)
            begin
                saved_cp_q <= cp_q;
                cp_q <= {ctx_new_i[15:1], 1'b0};
            end
            else if (wb_wr_d && wb_adr_i == REG_CP)
                cp_q <= {wb_dat_i[15:1], 1'b0};
        end
    end

    // saturating count of accesses that fail the per-kind checks (bad_d)
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            err_cnt_q <= 8'h0;
        else if (ce_i && req_i && bad_d && err_cnt_q != 8'hff)
            err_cnt_q <= err_cnt_q + 8'h1;
    end

    // wishbone: ack one cycle after strobe, dropped next cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else if (ce_i)
        begin
            wb_ack_o <= wb_req_d;
            if (wb_req_d)
            begin
                unique case (wb_adr_i)
                    REG_SYSCFG: wb_dat_o <= {29'h0, stack_size_field_q};
                    REG_SP: wb_dat_o <= {16'h0, sp_q};
                    REG_LOWER: wb_dat_o <= {16'h0, lower_q};
                    REG_UPPER: wb_dat_o <= {16'h0, upper_q};
                    REG_CP: wb_dat_o <= {16'h0, cp_q};
                    REG_SAVED_CP: wb_dat_o <= {16'h0, saved_cp_q};
                    REG_STATUS: wb_dat_o <= {23'h0, stack_size_field_q == STACK_SIZE_FIELD_MAX, err_cnt_q};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    chk_push_dec: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_i && kind_i == IRSM_PUSH && !bad_d |=> sp_q == $past(sp_q) - 16'h2)
        else $error("push did not lower stack pointer by two");
    chk_pop_inc: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_i && kind_i == IRSM_POP && !bad_d |=> sp_q == $past(sp_q) + 16'h2)
        else $error("pop did not raise stack pointer by two");
    chk_stack_byte: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_i && byte_i && (kind_i == IRSM_PUSH || kind_i == IRSM_POP) |=> err_o)
        else $error("byte stack access not refused");
    chk_ctx_save: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ctx_switch_i |=> saved_cp_q == $past(cp_q))
        else $error("context switch lost previous pointer");
    chk_page_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_i && kind_i == IRSM_LONG && dpp_page_i != RAM_PAGE |=> err_o)
        else $error("access outside page 3 not refused");
    chk_odd_word: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_i && kind_i == IRSM_LONG && !byte_i && addr_i[0] |=> err_o)
        else $error("odd word access not refused");
    chk_odd_fetch: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_i && kind_i == IRSM_FETCH && addr_i[0] |=> err_o)
        else $error("odd fetch not refused");
    chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack held two cycles");
    chk_size_lim: assert property (@(posedge clk_i) disable iff (rst_i)
        stack_size_field_q != 3'h5 && stack_size_field_q != 3'h6)
        else $error("reserved stack size code stored");
    cov_push: cover property (@(posedge clk_i) req_i && kind_i == IRSM_PUSH && !bad_d);
    cov_evt: cover property (@(posedge clk_i) req_i && kind_i == IRSM_EVT && we_i);
    cov_ctx: cover property (@(posedge clk_i) ctx_switch_i);
endmodule : irsm_core

// ---- testbench/irsm_cpu_model.sv ----
module irsm_cpu_model
    import irsm_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic [15:0] rdata_i,
    output logic req_o,
    output irsm_kind_type kind_o,
    output logic [3:0] ctl_o,
    output logic [15:0] addr_o,
    output logic [4:0] aux_o,
    output logic [15:0] wdata_o,
    output logic ctx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {req_o, ctl_o, addr_o, aux_o, wdata_o, ctx_o} = '0;
        kind_o = IRSM_LONG;
    end
    // ctl is {write, byte, page}; fetch addresses are passed on as given, odd ones included
    task automatic access(input irsm_kind_type k, input logic [3:0] c, input logic [15:0] a,
        input logic [4:0] x, input logic [15:0] d, output logic [15:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        kind_o <= k;
        {req_o, ctl_o, addr_o, aux_o, wdata_o} <= {1'b1, c, a, x, d};
        @(posedge clk_i);
        req_o <= 1'b0;
        // released address and data lines show the inverse, never the stale value
        {addr_o, wdata_o} <= ~{a, d};
        while (ack_i !== 1'b1 && n < 8)
        begin
            @(posedge clk_i);
            n++;
        end
        q = rdata_i;
        e = err_i;
    endtask : access
    task automatic switch_ctx(input logic [15:0] cp);
        @(posedge clk_i);
        {ctx_o, wdata_o} <= {1'b1, cp};
        @(posedge clk_i);
        ctx_o <= 1'b0;
    endtask : switch_ctx
endmodule : irsm_cpu_model

// ---- testbench/testbench.sv ----
module testbench
    import irsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = '0;
    logic [31:0] wb_dat_w = '0;
    logic [31:0] wb_dat_r, q;
    logic wb_ack, req, ack, err, special_registers, extended_special_registers, ctx, e;
    irsm_kind_type kind;
    logic [3:0] ctl;
    logic [4:0] aux;
    logic [15:0] addr, wdata, rdata, r;
    int failures = 0;
    int num_checks = 0;
    always #10 clk_i = ~clk_i;
    irsm_core #(.WORDS(1024)) i_irsm_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .req_i(req), .kind_i(kind), .we_i(ctl[3]), .byte_i(ctl[2]),
        .dpp_page_i(ctl[1:0]), .addr_i(addr), .reg_i(aux), .chan_i(aux[2:0]), .chan_dst_i(aux[3]),
        .bit_i(aux[3:0]), .wdata_i(wdata), .ctx_switch_i(ctx), .ctx_new_i(wdata), .rdata_o(rdata),
        .ack_o(ack), .err_o(err), .sfr_sel_o(special_registers), .extended_special_registers_sel_o(extended_special_registers));
    irsm_cpu_model i_irsm_cpu_model (.clk_i(clk_i), .ack_i(ack), .err_i(err), .rdata_i(rdata), .req_o(req),
        .kind_o(kind), .ctl_o(ctl), .addr_o(addr), .aux_o(aux), .wdata_o(wdata), .ctx_o(ctx));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d = '0);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, w, a, d};
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 8)
        begin
            @(posedge clk_i);
            n++;
        end
        if (wb_ack !== 1'b1)
            failures++;
        q = wb_dat_r;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask : wb
    task automatic op(input irsm_kind_type k, input logic [15:0] a = '0, input logic [15:0] d = '0,
        input logic w = 1'b0, input logic [4:0] x = '0, input logic b = 1'b0, input logic [1:0] pg = 2'h3,
        input logic ee = 1'b0);
        i_irsm_cpu_model.access(k, {w, b, pg}, a, x, d, r, e);
        check("refusal", 16'(e), 16'(ee));
    endtask : op
    task automatic t_regs;
        logic [7:0] adr [7] = '{REG_SYSCFG, REG_SP, REG_LOWER, REG_UPPER, REG_CP, REG_SAVED_CP, REG_STATUS};
        logic [15:0] rv [7] = '{16'h0, 16'hfc00, 16'hfa00, 16'hfc00, 16'hfc00, 16'hfc00, 16'h0};
        logic [15:0] low [8] = '{16'hfa00, 16'hfb00, 16'hfb80, 16'hfbc0, 16'hf800, 16'hf800, 16'hf800, 16'hf600};
        foreach (adr[i])
        begin
            wb(1'b0, adr[i]);
            check("reset value", q[15:0], rv[i]);
        end
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b1, REG_SYSCFG, 32'(i));
            wb(1'b0, REG_LOWER);
            check("lower limit", q[15:0], low[i]);
            wb(1'b0, REG_UPPER);
            check("upper limit", q[15:0], (i == 7) ? 16'hfe00 : 16'hfc00);
            wb(1'b0, REG_SYSCFG);
            check("size code", q[15:0], (i == 5 || i == 6) ? 16'h4 : 16'(i));
            wb(1'b0, REG_STATUS);
            check("full size mode", 16'(q[8]), 16'(i == 7));
        end
        wb(1'b1, 8'h1c, 32'h5a5a);
        wb(1'b0, 8'h1c);
        check("unmapped", q[15:0], 16'h0);
    endtask : t_regs
    task automatic t_stack;
        wb(1'b1, REG_SYSCFG, 32'h0);
        wb(1'b1, REG_SP, 32'hfc00);
        op(IRSM_PUSH, '0, 16'h1234, 1'b1);
        wb(1'b0, REG_SP);
        check("sp after push", q[15:0], 16'hfbfe);
        op(IRSM_LONG, 16'hfbfe);
        check("pushed word", r, 16'h1234);
        op(IRSM_PUSH, '0, 16'h1, 1'b1, '0, 1'b1, 2'h3, 1'b1);
        op(IRSM_POP);
        check("popped word", r, 16'h1234);
        op(IRSM_POP, '0, '0, 1'b0, '0, 1'b0, 2'h3, 1'b1);
        wb(1'b1, REG_SYSCFG, 32'h3);
        wb(1'b1, REG_SP, 32'hfbc0);
        op(IRSM_PUSH, '0, 16'h9, 1'b1, '0, 1'b0, 2'h3, 1'b1);
    endtask : t_stack
    task automatic t_data;
        op(IRSM_LONG, 16'hfd10, 16'ha55a, 1'b1);
        op(IRSM_LONG, 16'hfd11, 16'h003c, 1'b1, '0, 1'b1);
        op(IRSM_LONG, 16'hfd10);
        check("byte order", r, 16'h3c5a);
        op(IRSM_LONG, 16'hfd11, '0, 1'b0, '0, 1'b0, 2'h3, 1'b1);
        op(IRSM_LONG, 16'hfd10, '0, 1'b0, '0, 1'b0, 2'h2, 1'b1);
        op(IRSM_LONG, 16'hf600, 16'h0f0f, 1'b1);
        op(IRSM_LONG, 16'hfdfe, 16'h7777, 1'b1);
        op(IRSM_FETCH, 16'hfdfe);
        check("last word", r, 16'h7777);
        op(IRSM_LONG, 16'hf600);
        check("first word", r, 16'h0f0f);
        op(IRSM_FETCH, 16'hfdfd, '0, 1'b0, '0, 1'b0, 2'h3, 1'b1);
        op(IRSM_LONG, 16'hfe00, '0, 1'b0, '0, 1'b0, 2'h3, 1'b0);
        check("upper block select", 16'(special_registers), 16'h1);
        op(IRSM_LONG, 16'hf000, '0, 1'b0, '0, 1'b0, 2'h3, 1'b0);
        check("lower block select", 16'(extended_special_registers), 16'h1);
        op(IRSM_LONG, 16'hfd20, 16'h0, 1'b1);
        op(IRSM_BIT, 16'hfd20, 16'h1, 1'b1, 5'h3);
        op(IRSM_LONG, 16'hfd20);
        check("bit set", r, 16'h0008);
        op(IRSM_BIT, 16'hfc00, 16'h1, 1'b1, 5'h3, 1'b0, 2'h3, 1'b1);
    endtask : t_data
    task automatic t_bank;
        wb(1'b1, REG_CP, 32'hfc40);
        op(IRSM_GPR, '0, 16'hbeef, 1'b1, 5'd5, 1'b0, 2'h0);
        op(IRSM_GPR, '0, 16'h0011, 1'b1, 5'd15);
        op(IRSM_LONG, 16'hfc4a);
        check("word register", r, 16'hbeef);
        op(IRSM_LONG, 16'hfc5e);
        check("last register", r, 16'h0011);
        op(IRSM_GPR, '0, 16'h1122, 1'b1, 5'd2);
        op(IRSM_GPR, '0, 16'h00ab, 1'b1, 5'h05, 1'b1);
        op(IRSM_BIT, '0, 16'h1, 1'b1, 5'h02, 1'b1);
        op(IRSM_LONG, 16'hfc44);
        check("byte and bit", r, 16'hab26);
        wb(1'b1, REG_CP, 32'hfc80);
        op(IRSM_LONG, 16'hfc8a, 16'h5555, 1'b1);
        op(IRSM_GPR, '0, '0, 1'b0, 5'd5);
        check("new bank", r, 16'h5555);
        i_irsm_cpu_model.switch_ctx(16'hfca0);
        wb(1'b0, REG_SAVED_CP);
        check("saved pointer", q[15:0], 16'hfc80);
        wb(1'b0, REG_CP);
        check("switched pointer", q[15:0], 16'hfca0);
    endtask : t_bank
    task automatic t_event;
        op(IRSM_EVT, '0, 16'hc0de, 1'b1, 5'h0f, 1'b0, 2'h0);
        op(IRSM_LONG, 16'hfcfe);
        check("dest pointer 7", r, 16'hc0de);
        op(IRSM_LONG, 16'hfcec, 16'h4321, 1'b1);
        op(IRSM_EVT, '0, '0, 1'b0, 5'h03, 1'b0, 2'h1);
        check("src pointer 3", r, 16'h4321);
    endtask : t_event
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_stack();
        t_data();
        t_bank();
        t_event();
        end_sim();
    end
    initial
    begin
        repeat (4000) @(posedge clk_i);
        failures++;
        end_sim();
    end
endmodule : testbench
